/* tidr_cycle_delay.sv */
`timescale 1ns/1ps
// whole-cycle delay of one input after its fine delay
module tidr_cycle_delay
#(
  parameter int MAX_CYC = 3
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] cyc_i,
  input  wire logic       sig_i,
  output logic            sig_o
);
  import tidr_pkg::*;

  typedef struct packed {
    logic [MAX_CYC-1:0] pipe;
    logic               out;
  } tidr_cd_state_t;

  tidr_cd_state_t s_q;
  tidr_cd_state_t s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.pipe = {s_q.pipe[MAX_CYC-2:0], sig_i};
    if (cyc_i == 2'h0)
    begin
      s_d.out = sig_i;
    end
    else
    begin
      s_d.out = s_q.pipe[cyc_i-2'h1];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sig_o = s_q.out;

endmodule : tidr_cycle_delay

/* tidr_fine_model.sv */
`timescale 1ns/1ps
module tidr_fine_model
(
  input  wire logic                     clk_i,
  input  wire logic                     pin_i,
  input  wire tidr_pkg::tidr_fine_ctl_t ctl_i,
  output logic                          fine_o,
  output logic [8:0]                    taps_o
);
  import tidr_pkg::*;
  always_ff @(posedge clk_i)
  begin
    if (ctl_i.load)
      taps_o <= ctl_i.taps;
    fine_o <= pin_i;
  end
endmodule : tidr_fine_model

/* tidr_pkg.sv */
package tidr_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] TIDR_GATE_CTL_OFS   = 8'h00;
  localparam logic [7:0] TIDR_SYNC_CTL_OFS   = 8'h04;
  localparam logic [7:0] TIDR_AUX_CTL_OFS    = 8'h08;
  localparam logic [7:0] TIDR_SRC_SEL_OFS    = 8'h0C;
  localparam logic [7:0] TIDR_GATE_GEN_OFS   = 8'h10;
  localparam logic [7:0] TIDR_SYNC_GEN_OFS   = 8'h14;
  localparam logic [7:0] TIDR_PPS_GEN_OFS    = 8'h18;
  localparam logic [7:0] TIDR_STATUS_OFS     = 8'h1C;
  localparam logic [7:0] TIDR_IRQ_EN_OFS     = 8'h20;
  localparam logic [7:0] TIDR_IRQ_SRC_OFS    = 8'h24;
  localparam logic [7:0] TIDR_IRQ_FLAG_OFS   = 8'h28;

  // ==========================================================================
  // gate control field positions
  localparam int TIDR_DIFF_TAP_LSB  = 0;
  localparam int TIDR_LOAD_BIT      = 9;
  localparam int TIDR_DIFF_CYC_LSB  = 12;
  localparam int TIDR_TTL_TAP_LSB   = 16;
  localparam int TIDR_TTL_CYC_LSB   = 28;
  localparam int TIDR_TAP_W         = 9;
  localparam int TIDR_CYC_W         = 2;
  localparam logic [31:0] TIDR_CTL_WMASK = 32'h33FF_33FF;

  // ==========================================================================
  // reset values and irq bit layout
  localparam logic [31:0] TIDR_REG_RST   = 32'h0000_0000;
  localparam logic [8:0]  TIDR_TAP_RST   = 9'h000;
  localparam int          TIDR_IRQ_BITS  = 4;
  localparam int          TIDR_IRQ_GATE_DIFF = 0;
  localparam int          TIDR_IRQ_GATE_TTL  = 1;
  localparam int          TIDR_IRQ_SYNC_DIFF = 2;
  localparam int          TIDR_IRQ_SYNC_TTL  = 3;

  // ==========================================================================
  // bus carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tidr_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] dat;
  } tidr_wb_rsp_t;

  // fine delay element control for one input
  typedef struct packed {
    logic       load;
    logic [8:0] taps;
  } tidr_fine_ctl_t;

endpackage : tidr_pkg

/* tidr_regs.sv */
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
// How it works
// - gate control register at 0x00 sets fine and cycle delay, both gate inputs.
// - sync control register at 0x04 holds fine and cycle delay of sync inputs.
// - auxiliary control register at 0x08 holds delay of the coaxial gate input.
// - source select register at 0x0C picks drive, receive and led sources.
// - soft gate, sync and pps registers sit at 0x10, 0x14 and 0x18.
// - read-only status at 0x1C shows output sources and input states.
// - irq enable at 0x20, source status at 0x24, flags at 0x28.
// - ttl gate input delayed by bits 29:28 plus one whole cycles after fine delay.
// - bits 24:16 give ttl gate fine delay taps, 0 to 511.
// - lvds gate input delayed by bits 13:12 plus one whole cycles after fine delay.
// - bits 8:0 give lvds gate fine delay taps of 512-tap line.
// - writing bit 9 one then zero loads both tap counts; resets to 0.
// - all timing and counting runs on the single sample clock.
module tidr_regs
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire tidr_pkg::tidr_wb_req_t  wb_req_i,
  output tidr_pkg::tidr_wb_rsp_t       wb_rsp_o,
  input  wire logic                    gate_diff_i,
  input  wire logic                    gate_ttl_i,
  input  wire logic                    sync_diff_i,
  input  wire logic                    sync_ttl_i,
  input  wire logic                    gate_diff_fine_i,
  input  wire logic                    gate_ttl_fine_i,
  output tidr_pkg::tidr_fine_ctl_t     gate_diff_fine_o,
  output tidr_pkg::tidr_fine_ctl_t     gate_ttl_fine_o,
  output logic                         gate_diff_o,
  output logic                         gate_ttl_o,
  output logic [31:0]                  sync_ctl_o,
  output logic [31:0]                  aux_ctl_o,
  output logic [31:0]                  src_sel_o,
  output logic [31:0]                  gate_gen_o,
  output logic [31:0]                  sync_gen_o,
  output logic [31:0]                  pps_gen_o,
  input  wire logic [15:0]             src_status_i,
  output logic                         irq_o
);
  import tidr_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [31:0]              gate_ctl;
    logic [31:0]              sync_ctl;
    logic [31:0]              aux_ctl;
    logic [31:0]              src_sel;
    logic [31:0]              gate_gen;
    logic [31:0]              sync_gen;
    logic [31:0]              pps_gen;
    logic [TIDR_IRQ_BITS-1:0] irq_en;
    logic [TIDR_IRQ_BITS-1:0] irq_flag;
    logic [TIDR_IRQ_BITS-1:0] in_s1;
    logic [TIDR_IRQ_BITS-1:0] in_s2;
    logic [TIDR_IRQ_BITS-1:0] in_prev;
    logic                     load_armed;
    logic                     load;
    logic [8:0]               diff_taps;
    logic [8:0]               ttl_taps;
    logic                     ack;
    logic                     err;
    logic [31:0]              rdat;
  } tidr_state_t;

  tidr_state_t s_q;
  tidr_state_t s_d;

  logic [31:0]              wmask;
  logic                     wr_go;
  logic                     req_go;
  logic [31:0]              gate_wr;
  logic [TIDR_IRQ_BITS-1:0] rise;

  // ==========================================================================
  // byte lane mask and request decode
  assign wmask  = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                   {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
  assign req_go = wb_req_i.cyc & wb_req_i.stb & ~s_q.ack & ~s_q.err;
  assign wr_go  = req_go & wb_req_i.we;
  assign rise   = s_q.in_s2 & ~s_q.in_prev;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  assign gate_wr = merge(s_q.gate_ctl, wb_req_i.dat, wmask)
                 & TIDR_CTL_WMASK;

  // ==========================================================================
  // next state
  always_comb
  begin
    s_d         = s_q;
    s_d.ack     = 1'b0;
    s_d.err     = 1'b0;
    s_d.load    = 1'b0;
    s_d.in_s1   = {sync_ttl_i, sync_diff_i, gate_ttl_i, gate_diff_i};
    s_d.in_s2   = s_q.in_s1;
    s_d.in_prev = s_q.in_s2;
    // events set flags; set wins over a same-cycle clear
    s_d.irq_flag = s_q.irq_flag;
    if (req_go)
    begin
      s_d.ack = 1'b1;
      case (wb_req_i.adr)
        TIDR_GATE_CTL_OFS: s_d.rdat = s_q.gate_ctl;
        TIDR_SYNC_CTL_OFS: s_d.rdat = s_q.sync_ctl;
        TIDR_AUX_CTL_OFS:  s_d.rdat = s_q.aux_ctl;
        TIDR_SRC_SEL_OFS:  s_d.rdat = s_q.src_sel;
        TIDR_GATE_GEN_OFS: s_d.rdat = s_q.gate_gen;
        TIDR_SYNC_GEN_OFS: s_d.rdat = s_q.sync_gen;
        TIDR_PPS_GEN_OFS:  s_d.rdat = s_q.pps_gen;
        TIDR_STATUS_OFS:   s_d.rdat = {12'h000, s_q.in_s2, src_status_i};
        TIDR_IRQ_EN_OFS:   s_d.rdat = {28'h0000000, s_q.irq_en};
        TIDR_IRQ_SRC_OFS:  s_d.rdat = {28'h0000000, s_q.in_s2};
        TIDR_IRQ_FLAG_OFS: s_d.rdat = {28'h0000000, s_q.irq_flag};
        default:
        begin
          s_d.ack  = 1'b0;
          s_d.err  = 1'b1;
          s_d.rdat = 32'h0000_0000;
        end
      endcase
      if (wb_req_i.we)
      begin
        s_d.rdat = 32'h0000_0000;
      end
    end
    if (wr_go)
    begin
      case (wb_req_i.adr)
        TIDR_GATE_CTL_OFS:
        begin
          s_d.gate_ctl = gate_wr;
          // load on the one-then-zero sequence of the load bit
          if (gate_wr[TIDR_LOAD_BIT])
          begin
            s_d.load_armed = 1'b1;
          end
          else if (s_q.load_armed)
          begin
            s_d.load_armed = 1'b0;
            s_d.load       = 1'b1;
            // new taps go out together with the load pulse
            s_d.diff_taps  = gate_wr[TIDR_DIFF_TAP_LSB +: TIDR_TAP_W];
            s_d.ttl_taps   = gate_wr[TIDR_TTL_TAP_LSB +: TIDR_TAP_W];
          end
        end
        TIDR_SYNC_CTL_OFS:
          s_d.sync_ctl = merge(s_q.sync_ctl, wb_req_i.dat, wmask);
        TIDR_AUX_CTL_OFS:
          s_d.aux_ctl  = merge(s_q.aux_ctl, wb_req_i.dat, wmask);
        TIDR_SRC_SEL_OFS:
          s_d.src_sel  = merge(s_q.src_sel, wb_req_i.dat, wmask);
        TIDR_GATE_GEN_OFS:
          s_d.gate_gen = merge(s_q.gate_gen, wb_req_i.dat, wmask);
        TIDR_SYNC_GEN_OFS:
          s_d.sync_gen = merge(s_q.sync_gen, wb_req_i.dat, wmask);
        TIDR_PPS_GEN_OFS:
          s_d.pps_gen  = merge(s_q.pps_gen, wb_req_i.dat, wmask);
        TIDR_IRQ_EN_OFS:
          if (wb_req_i.sel[0])
          begin
            s_d.irq_en = wb_req_i.dat[TIDR_IRQ_BITS-1:0];
          end
        TIDR_IRQ_FLAG_OFS:
          if (wb_req_i.sel[0])
          begin
            // write one to clear
            s_d.irq_flag = s_q.irq_flag
                         & ~wb_req_i.dat[TIDR_IRQ_BITS-1:0];
          end
        default:
        begin
        end
      endcase
    end
    s_d.irq_flag = s_d.irq_flag | rise;
  end

  // ==========================================================================
  // registers on the sample clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // whole-cycle delays after the fine delay elements
  tidr_cycle_delay u_diff_dly
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cyc_i (s_q.gate_ctl[TIDR_DIFF_CYC_LSB +: TIDR_CYC_W]),
    .sig_i (gate_diff_fine_i),
    .sig_o (gate_diff_o)
  );

  tidr_cycle_delay u_ttl_dly
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cyc_i (s_q.gate_ctl[TIDR_TTL_CYC_LSB +: TIDR_CYC_W]),
    .sig_i (gate_ttl_fine_i),
    .sig_o (gate_ttl_o)
  );

  // ==========================================================================
  // outputs
  assign gate_diff_fine_o = '{load: s_q.load, taps: s_q.diff_taps};
  assign gate_ttl_fine_o  = '{load: s_q.load, taps: s_q.ttl_taps};
  assign wb_rsp_o         = '{ack: s_q.ack, err: s_q.err, dat: s_q.rdat};
  assign sync_ctl_o       = s_q.sync_ctl;
  assign aux_ctl_o        = s_q.aux_ctl;
  assign src_sel_o        = s_q.src_sel;
  assign gate_gen_o       = s_q.gate_gen;
  assign sync_gen_o       = s_q.sync_gen;
  assign pps_gen_o        = s_q.pps_gen;
  assign irq_o            = |(s_q.irq_flag & s_q.irq_en);

endmodule : tidr_regs

/* tidr_regs_sva.sv */
`timescale 1ns/1ps
module tidr_regs_sva
(
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire tidr_pkg::tidr_wb_req_t   wb_req_i,
  input wire tidr_pkg::tidr_wb_rsp_t   wb_rsp_o,
  input wire tidr_pkg::tidr_fine_ctl_t gate_diff_fine_o,
  input wire tidr_pkg::tidr_fine_ctl_t gate_ttl_fine_o,
  input wire logic [15:0]              src_status_i
);
  import tidr_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic tk;
  logic clr_w;
  assign tk = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack && !wb_rsp_o.err;
  assign clr_w = wb_rsp_o.ack && wb_req_i.we && !wb_req_i.dat[TIDR_LOAD_BIT]
                 && wb_req_i.adr == TIDR_GATE_CTL_OFS;
  // ==========================================================================
  // bus answer
  sequence s_take;
    tk;
  endsequence
  sequence s_answer;
    (wb_rsp_o.ack ^ wb_rsp_o.err) ##1 !(wb_rsp_o.ack || wb_rsp_o.err);
  endsequence
  AST_ANSWER: assert property (s_take |=> s_answer)
    else $error("bus answer not a single pulse");
  AST_UNMAPPED: assert property (tk && wb_req_i.adr > TIDR_IRQ_FLAG_OFS
    && wb_req_i.adr[1:0] == 2'h0 |=> wb_rsp_o.err)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (tk && wb_req_i.adr <= TIDR_IRQ_FLAG_OFS
    && wb_req_i.adr[1:0] == 2'h0 |=> wb_rsp_o.ack)
    else $error("mapped access not acked");
  AST_RSV_ZERO: assert property (wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr
    == TIDR_GATE_CTL_OFS |-> (wb_rsp_o.dat & ~TIDR_CTL_WMASK) == 32'h0)
    else $error("reserved gate bits not zero");
  AST_STATUS: assert property (tk && !wb_req_i.we && wb_req_i.adr ==
    TIDR_STATUS_OFS |=> wb_rsp_o.dat[15:0] == $past(src_status_i))
    else $error("status read wrong");
  // ==========================================================================
  // fine delay load
  AST_LOAD_CAUSE: assert property (gate_diff_fine_o.load |-> clr_w)
    else $error("load without clear write");
  AST_LOAD_BOTH: assert property
    (gate_diff_fine_o.load == gate_ttl_fine_o.load)
    else $error("loads not together");
  AST_LOAD_PULSE: assert property
    (gate_diff_fine_o.load |=> !gate_diff_fine_o.load)
    else $error("load longer than one cycle");
  AST_TAPS_HOLD: assert property (!gate_diff_fine_o.load |->
    $stable({gate_diff_fine_o.taps, gate_ttl_fine_o.taps}))
    else $error("taps moved without load");
  AST_TAPS_VAL: assert property (gate_diff_fine_o.load |->
    gate_diff_fine_o.taps == $past(wb_req_i.dat[8:0])
    && gate_ttl_fine_o.taps == $past(wb_req_i.dat[24:16]))
    else $error("loaded taps wrong");
endmodule : tidr_regs_sva

bind tidr_regs tidr_regs_sva tidr_regs_sva_i (
  .clk_i            (clk_i),
  .rst_i            (rst_i),
  .wb_req_i         (wb_req_i),
  .wb_rsp_o         (wb_rsp_o),
  .gate_diff_fine_o (gate_diff_fine_o),
  .gate_ttl_fine_o  (gate_ttl_fine_o),
  .src_status_i     (src_status_i)
);

/* timing_input_delay_regs_test.sv */
`timescale 1ns/1ps
module timing_input_delay_regs_test;
  import tidr_pkg::*;
  logic           clk_i;
  logic           rst_i;
  tidr_wb_req_t   req;
  tidr_wb_rsp_t   rsp;
  logic [3:0]     pin;
  logic           rnd_en;
  logic           fd;
  logic           ft;
  logic           od;
  logic           ot;
  logic [15:0]    sts;
  logic           irq;
  tidr_fine_ctl_t cd;
  tidr_fine_ctl_t ct;
  wire [31:0]     so [6];
  logic [4:0]     hd;
  logic [4:0]     ht;
  logic [17:0]    mt;
  logic [31:0]    rd;
  logic           er;
  logic [31:0]    v;
  int             fails;
  int             comparisons;
  tidr_regs tidr_regs_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_rsp_o(rsp), .gate_diff_i(pin[0]), .gate_ttl_i(pin[1]),
    .sync_diff_i(pin[2]), .sync_ttl_i(pin[3]), .gate_diff_fine_i(fd),
    .gate_ttl_fine_i(ft), .gate_diff_fine_o(cd), .gate_ttl_fine_o(ct),
    .gate_diff_o(od), .gate_ttl_o(ot), .sync_ctl_o(so[0]), .aux_ctl_o(so[1]),
    .src_sel_o(so[2]), .gate_gen_o(so[3]), .sync_gen_o(so[4]),
    .pps_gen_o(so[5]), .src_status_i(sts), .irq_o(irq));
  tidr_fine_model tidr_fine_model_d_i (.clk_i(clk_i), .pin_i(pin[0]),
    .ctl_i(cd), .fine_o(fd), .taps_o(mt[17:9]));
  tidr_fine_model tidr_fine_model_t_i (.clk_i(clk_i), .pin_i(pin[1]),
    .ctl_i(ct), .fine_o(ft), .taps_o(mt[8:0]));
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    hd <= {hd[3:0], fd};
    ht <= {ht[3:0], ft};
    if (rnd_en)
      pin <= 4'($urandom);
  end
  // ==========================================================================
  // tasks
  task automatic end_sim;
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] s, input logic [31:0] e, string n);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, a, 4'hF, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (rsp.ack !== 1'b1 && rsp.err !== 1'b1 && n < 20);
    if (rsp.ack !== 1'b1 && rsp.err !== 1'b1)
    begin
      fails++;
      end_sim;
    end
    rd = rsp.dat;
    er = rsp.err;
    req <= '0;
  endtask : wb
  // ==========================================================================
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    req = '0;
    pin = 4'h0;
    rnd_en = 1'b0;
    fails = 0;
    comparisons = 0;
    void'($urandom(32'h74385E4F));
    sts = 16'($urandom);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 8'h28; a += 4)
    begin
      wb(1'b0, 8'(a), 32'h0);
      chk(rd, (a == 8'h1C) ? {16'h0, sts} : TIDR_REG_RST, "rst");
      chk({31'h0, er}, 32'h0, "err");
    end
    for (int a = 4; a <= 8'h18; a += 4)
    begin
      v = $urandom;
      wb(1'b1, 8'(a), v);
      wb(1'b0, 8'(a), 32'h0);
      chk(rd, v, "rw");
      chk(so[a / 4 - 1], v, "out");
    end
    v = $urandom | 32'h200;
    wb(1'b1, TIDR_GATE_CTL_OFS, v);
    wb(1'b0, TIDR_GATE_CTL_OFS, 32'h0);
    chk(rd, v & TIDR_CTL_WMASK, "gate");
    chk({cd.taps, ct.taps}, 32'h0, "taps");
    v = ($urandom & ~32'h200) | 32'h1FF;
    wb(1'b1, TIDR_GATE_CTL_OFS, v);
    repeat (3) @(posedge clk_i);
    chk({cd.taps, ct.taps}, {v[8:0], v[24:16]}, "load");
    chk({14'h0, mt}, {14'h0, v[8:0], v[24:16]}, "model");
    wb(1'b1, TIDR_STATUS_OFS, 32'hFFFFFFFF);
    wb(1'b0, TIDR_STATUS_OFS, 32'h0);
    chk(rd, {16'h0, sts}, "ro");
    wb(1'b0, 8'h2C, 32'h0);
    chk({31'h0, er}, 32'h1, "unmap");
    rnd_en <= 1'b1;
    for (int n = 0; n < 4; n++)
    begin
      wb(1'b1, TIDR_GATE_CTL_OFS, (n << 28) | ((3 - n) << 12));
      repeat (6) @(posedge clk_i);
      repeat (16)
      begin
        @(posedge clk_i);
        chk({31'h0, od}, {31'h0, hd[3 - n]}, "ddly");
        chk({31'h0, ot}, {31'h0, ht[n]}, "tdly");
      end
    end
    rnd_en <= 1'b0;
    chk({cd.taps, ct.taps}, {v[8:0], v[24:16]}, "hold");
    @(posedge clk_i);
    pin <= 4'h0;
    repeat (4) @(posedge clk_i);
    wb(1'b1, TIDR_IRQ_FLAG_OFS, 32'hF);
    wb(1'b1, TIDR_IRQ_EN_OFS, 32'h0);
    pin <= 4'h1;
    repeat (8) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0, "mask");
    wb(1'b0, TIDR_IRQ_FLAG_OFS, 32'h0);
    chk(rd, 32'h1, "flag");
    wb(1'b0, TIDR_IRQ_SRC_OFS, 32'h0);
    chk(rd, 32'h1, "src");
    wb(1'b1, TIDR_IRQ_EN_OFS, 32'h1);
    for (int i = 0; i < 10 && irq !== 1'b1; i++)
      @(posedge clk_i);
    chk({31'h0, irq}, 32'h1, "irq");
    wb(1'b1, TIDR_IRQ_FLAG_OFS, 32'h1);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0, "clear");
    end_sim;
  end
endmodule : timing_input_delay_regs_test
